// ==== err_therm_pkg.sv ====
// Package with timing constants and state codes for the error and thermal signalling block.
package err_therm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned FAULT_PULSE_CYCLES = 16;     // Machine-check pulse length in bus clocks.
    localparam int unsigned PULSE_CNT_W        = 5;      // Counter width, holds 0..16.
    localparam logic [PULSE_CNT_W-1:0] PULSE_LEN = 5'h10; // Pulse length at counter width.
    localparam logic [PULSE_CNT_W-1:0] CNT_ZERO  = 5'h00; // Idle counter value.
    localparam logic [PULSE_CNT_W-1:0] CNT_ONE   = 5'h01; // Decrement step.

    // ------------------------------------------------------------
    // Fatal-error sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FE_IDLE  = 2'b00,  // Output released.
        FE_PULSE = 2'b01,  // Timed machine-check pulse.
        FE_LATCH = 2'b10   // Held until reset.
    } fe_state_e;

endpackage : err_therm_pkg

// ==== therm_if.sv ====
// Interface carrying thermal status between the top module and the throttle unit.
`timescale 1ns/100ps
`default_nettype none
interface therm_if;
    logic hot_req;       // Internal sensor at maximum safe temperature.
    logic ext_hot;       // Over-temperature pin driven low from outside.
    logic throttle_en;   // Throttle circuit enabled.
    logic throttle_on;   // Throttle circuit active.
    logic drive_pin;     // Device pulls the over-temperature pin low.

    modport top (output hot_req, output ext_hot, output throttle_en,
                 input throttle_on, input drive_pin);
    modport unit (input hot_req, input ext_hot, input throttle_en,
                  output throttle_on, output drive_pin);
endinterface : therm_if
`default_nettype wire

// ==== thermal_throttle_unit.sv ====
// Thermal throttle unit: drives the over-temperature pin and the throttle activity.
`timescale 1ns/100ps
`default_nettype none
module thermal_throttle_unit
    import err_therm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    therm_if.unit     tif
);
    import err_therm_pkg::*;

    // ------------------------------------------------------------
    // Pin drive and throttle
    // ------------------------------------------------------------
    logic drive_q;    // Registered pin pull-down.
    logic throttle_q; // Registered throttle activity.
    logic throttle_d; // Next throttle value.

    // Throttle follows either hot source, but only while enabled.
    assign throttle_d = tif.throttle_en & (tif.hot_req | tif.ext_hot); // [R5] [R6]

    // The pin is pulled low only for our own sensor; an external
    // assertion is never echoed, which would latch the wire forever.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            drive_q    <= 1'b0;
            throttle_q <= 1'b0;
        end
        else
        begin
            drive_q    <= tif.hot_req; // [R4]
            throttle_q <= throttle_d;
        end
    end

    assign tif.drive_pin   = drive_q;
    assign tif.throttle_on = throttle_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pin_follows_hot: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        tif.hot_req |=> tif.drive_pin)
        else $error("pin not driven while hot");
    a_throttle_gated: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        !tif.throttle_en |=> !tif.throttle_on)
        else $error("throttle active while disabled");
    a_ext_throttle: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        (tif.ext_hot && tif.throttle_en) |=> tif.throttle_on)
        else $error("external hot did not throttle");
    c_ext_throttle: cover property (@(posedge clk_sys) disable iff (rst)
        tif.ext_hot && !tif.hot_req ##1 tif.throttle_on);
endmodule : thermal_throttle_unit
`default_nettype wire

// ==== error_thermal_signalling.sv ====
// Top of the fatal-error and thermal signalling logic.
//
// Summary of operation
// R1: Machine-check fault pulses fatal output 16 cycles.
// R2: Internal fault holds fatal output until reset.
// R3: Only unrecoverable faults assert the fatal output.
// R4: Drive over-temperature pin at maximum safe temperature.
// R5: Over-temperature throttles only when throttling enabled.
// R6: External over-temperature drive also activates throttling.
// R7: Shutdown temperature halts execution, asserts shutdown output.
// R8: Active-low pins; fatal and shutdown inactive after reset.
`timescale 1ns/100ps
`default_nettype none
module error_thermal_signalling
    import err_therm_pkg::*;
(
    input  wire logic clk_sys,             // Bus clock, 10 MHz.
    input  wire logic rst,                 // Synchronous reset, warm or cold.
    input  wire logic machine_check_fault, // One-cycle: non-recoverable machine check.
    input  wire logic internal_fault,      // One-cycle: unrecoverable internal fault.
    input  wire logic temp_at_max,         // Level: sensor at maximum safe temperature.
    input  wire logic temp_trip,           // Level: junction above the trip point.
    input  wire logic throttle_enable,     // Level: throttle circuit enabled.
    output logic      fatal_error_n,       // Fatal-error output, active low.
    input  wire logic over_temp_n_in,      // Over-temperature pin level, active low.
    output logic      over_temp_n_out,     // Over-temperature drive value, always low.
    output logic      over_temp_n_oe,      // High while the device pulls the pin.
    output logic      throttle_active,     // Throttle circuit active.
    output logic      thermal_shutdown_n,  // Thermal shutdown, active low.
    output logic      exec_halt            // Stops all instruction execution.
);
    import err_therm_pkg::*;

    // ------------------------------------------------------------
    // Fatal-error sequencer
    // ------------------------------------------------------------
    fe_state_e               fe_q;     // Sequencer state.
    fe_state_e               fe_d;     // Next state.
    logic [PULSE_CNT_W-1:0]  cnt_q;    // Remaining pulse cycles.
    logic [PULSE_CNT_W-1:0]  cnt_d;    // Next counter value.
    logic                    fatal_q;  // Registered active-high fatal flag.
    logic                    pulse_end; // Last pulse cycle.

    assign pulse_end = (cnt_q == CNT_ONE);

    // Internal fault outranks everything and is sticky; a machine check
    // during a running pulse does not restart it, so the length stays fixed.
    always_comb
    begin
        fe_d  = fe_q;
        cnt_d = cnt_q;
        case (fe_q)
            FE_IDLE:
            begin
                if (internal_fault)
                begin
                    fe_d = FE_LATCH; // [R2] [R3]
                end
                else if (machine_check_fault)
                begin
                    fe_d  = FE_PULSE; // [R1] [R3]
                    cnt_d = PULSE_LEN;
                end
            end
            FE_PULSE:
            begin
                if (internal_fault)
                begin
                    fe_d  = FE_LATCH; // [R2]
                    cnt_d = CNT_ZERO;
                end
                else if (pulse_end)
                begin
                    fe_d  = FE_IDLE; // [R1]
                    cnt_d = CNT_ZERO;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            FE_LATCH:
            begin
                fe_d = FE_LATCH; // [R2]
            end
            default:
            begin
                fe_d  = FE_IDLE;
                cnt_d = CNT_ZERO;
            end
        endcase
    end

    // State registers; reset is the only exit from the latched state.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fe_q  <= FE_IDLE; // [R8]
            cnt_q <= CNT_ZERO;
        end
        else
        begin
            fe_q  <= fe_d;
            cnt_q <= cnt_d;
        end
    end

    // Output flop, so the pin is glitch free.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fatal_q <= 1'b0; // [R8]
        end
        else
        begin
            fatal_q <= (fe_d != FE_IDLE);
        end
    end

    assign fatal_error_n = ~fatal_q; // [R8]

    // ------------------------------------------------------------
    // Thermal shutdown
    // ------------------------------------------------------------
    logic trip_q; // Sticky trip; cooling does not resume execution.

    // Once tripped, only reset clears it; a warm reset on rst is enough, no power cycle.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            trip_q <= 1'b0; // [R8]
        end
        else if (temp_trip)
        begin
            trip_q <= 1'b1; // [R7]
        end
    end

    assign thermal_shutdown_n = ~trip_q; // [R7]
    assign exec_halt          = trip_q;  // [R7]

    // ------------------------------------------------------------
    // Over-temperature pin and throttle
    // ------------------------------------------------------------
    therm_if tif ();

    assign tif.hot_req     = temp_at_max;
    assign tif.ext_hot     = ~over_temp_n_in & ~tif.drive_pin; // [R6]
    assign tif.throttle_en = throttle_enable;

    thermal_throttle_unit u_throttle (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tif     (tif)
    );

    // Open drain: the driven value is always low, only the enable moves.
    assign over_temp_n_out = 1'b0;           // [R4]
    assign over_temp_n_oe  = tif.drive_pin;  // [R4]
    assign throttle_active = tif.throttle_on;

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Measures the fatal pulse apart from the sequencer counter, so a wrong
    // reload or end compare shows up; a long repetition in a property would
    // cost the tools far more than this small counter does.
    logic [PULSE_CNT_W-1:0] low_run_q;  // Consecutive cycles with the fatal output low.
    logic                   low_sat;    // Counter at its ceiling, one past the pulse.
    logic [PULSE_CNT_W-1:0] pulse_last; // Count seen on the last pulse cycle.

    assign low_sat    = (low_run_q == PULSE_LEN + CNT_ONE);
    assign pulse_last = PULSE_LEN - CNT_ONE;

    // Cleared while the output is high, so each pulse is measured alone.
    always_ff @(posedge clk_sys)
    begin
        if (rst || fatal_error_n)
        begin
            low_run_q <= CNT_ZERO;
        end
        else if (!low_sat)
        begin
            low_run_q <= low_run_q + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The early-release and end pulse checks lean on the helper counter; an internal fault inside a
    // pulse legally turns it into a held level, so those cases are let through.
    a_mc_pulse_len: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        (fe_q == FE_IDLE && machine_check_fault && !internal_fault) |=>
        (!fatal_error_n && fe_q != FE_IDLE)[*8])
        else $error("machine check pulse too short");
    a_mc_no_early: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        (fe_q == FE_PULSE && low_run_q < pulse_last) |=> !fatal_error_n)
        else $error("machine check pulse released early");
    a_mc_pulse_end: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
        (fe_q == FE_PULSE && low_run_q == pulse_last && !internal_fault) |=> fatal_error_n)
        else $error("machine check pulse not released after 16");
    a_internal_holds: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        (internal_fault) |=> (!fatal_error_n)[*8])
        else $error("internal fault not held");
    a_no_cause: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        (fe_q == FE_IDLE && !machine_check_fault && !internal_fault) |=> fatal_error_n)
        else $error("fatal output without cause");
    a_trip_halts: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
        temp_trip |=> (!thermal_shutdown_n && exec_halt))
        else $error("trip did not halt");
    a_reset_idle: assert property (@(posedge clk_sys) // [R8]
        rst |=> (fatal_error_n && thermal_shutdown_n))
        else $error("outputs active after reset");

    // Cover points for the main scenarios: a full pulse, a held level and a trip.
    c_mc_pulse: cover property (@(posedge clk_sys) disable iff (rst)
        machine_check_fault ##17 fatal_error_n);
    c_internal: cover property (@(posedge clk_sys) disable iff (rst)
        internal_fault ##2 !fatal_error_n);
    c_trip: cover property (@(posedge clk_sys) disable iff (rst)
        temp_trip ##1 exec_halt);
endmodule : error_thermal_signalling
`default_nettype wire

// ==== platform_model.sv ====
// Board-side model of the over-temperature pin: open-drain wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module platform_model
(
    input  wire logic over_temp_n_out, // Device drive value.
    input  wire logic over_temp_n_oe,  // Device pulls the pin while high.
    input  wire logic board_pull,      // Board controller pulls the pin low.
    output logic      over_temp_n_in   // Resolved pin level.
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Either party may sink the line; the pull-up wins only when both let go.
    wire dev_low = over_temp_n_oe && (over_temp_n_out == 1'b0); // Device sinks.
    assign over_temp_n_in = (dev_low || board_pull) ? 1'b0 : 1'b1;
endmodule : platform_model
`default_nettype wire

// ==== error_thermal_signalling_tb.sv ====
// Self-checking bench for the fatal-error and thermal signalling block.
`timescale 1ns/100ps
`default_nettype none
module error_thermal_signalling_tb;
    logic clk_sys = 1'b0;    // Bus clock, 100 ns period.
    logic rst = 1'b1;        // Synchronous reset.
    logic mc = 1'b0;         // Machine-check fault stimulus.
    logic ie = 1'b0;         // Internal fault stimulus.
    logic hot = 1'b0;        // Sensor at maximum safe temperature.
    logic trip = 1'b0;       // Junction above trip point.
    logic ten = 1'b0;        // Throttle enable.
    logic pull = 1'b0;       // Board pulls the pin low.
    logic pin, ot_out, ot_oe, thr, fe_n, sd_n, halt; // Observed wires.
    int err_count = 0;       // Mismatches seen.
    int samples_checked = 0; // Comparisons made.
    int cyc = 0;             // Cycle counter for the hang guard.

    always #50 clk_sys = ~clk_sys;

    error_thermal_signalling DUT (.clk_sys(clk_sys), .rst(rst), .machine_check_fault(mc),
        .internal_fault(ie), .temp_at_max(hot), .temp_trip(trip), .throttle_enable(ten),
        .fatal_error_n(fe_n), .over_temp_n_in(pin), .over_temp_n_out(ot_out),
        .over_temp_n_oe(ot_oe), .throttle_active(thr), .thermal_shutdown_n(sd_n),
        .exec_halt(halt));
    platform_model board (.over_temp_n_out(ot_out), .over_temp_n_oe(ot_oe),
        .board_pull(pull), .over_temp_n_in(pin));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done;
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk

    // Reset is held over a whole number of edges, then idle outputs are checked.
    task automatic do_reset(input int n);
        rst = 1'b1;
        repeat (n) @(negedge clk_sys);
        rst = 1'b0;
        chk("fatal_error_n", fe_n, 1'b1);
        chk("thermal_shutdown_n", sd_n, 1'b1);
        chk("exec_halt", halt, 1'b0);
    endtask : do_reset

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // A second machine check inside the pulse must not stretch it.
    task automatic t_mc;
        mc = 1'b1;
        for (int i = 1; i <= 16; i++)
        begin
            @(negedge clk_sys);
            mc = (i == 5);
            chk("fatal_error_n pulse", fe_n, 1'b0);
        end
        @(negedge clk_sys);
        chk("fatal_error_n end", fe_n, 1'b1);
    endtask : t_mc

    // The internal fault level outlives any pulse and clears only on reset.
    task automatic t_internal;
        ie = 1'b1;
        @(negedge clk_sys) ie = 1'b0;
        repeat (40) @(negedge clk_sys);
        chk("fatal_error_n held", fe_n, 1'b0);
        do_reset(1);
    endtask : t_internal

    // An internal fault inside a running pulse turns it into a held level.
    task automatic t_internal_mid;
        mc = 1'b1;
        @(negedge clk_sys) mc = 1'b0;
        repeat (3) @(negedge clk_sys);
        ie = 1'b1;
        @(negedge clk_sys) ie = 1'b0;
        repeat (30) @(negedge clk_sys);
        chk("fatal_error_n latched", fe_n, 1'b0);
        do_reset(1);
    endtask : t_internal_mid

    // Own over-temperature drive, with throttling off and then on.
    task automatic t_hot;
        hot = 1'b1;
        @(negedge clk_sys);
        chk("over_temp_n_oe", ot_oe, 1'b1);
        chk("over_temp_n_out", ot_out, 1'b0);
        chk("throttle off", thr, 1'b0);
        ten = 1'b1;
        @(negedge clk_sys);
        chk("throttle on", thr, 1'b1);
        hot = 1'b0;
        @(negedge clk_sys);
        chk("over_temp_n_oe idle", ot_oe, 1'b0);
        chk("throttle idle", thr, 1'b0);
        chk("fatal_error_n quiet", fe_n, 1'b1);
    endtask : t_hot

    // The board pulls the pin; throttling follows while enabled.
    task automatic t_ext;
        pull = 1'b1;
        @(negedge clk_sys);
        chk("throttle external", thr, 1'b1);
        chk("over_temp_n_oe external", ot_oe, 1'b0);
        ten = 1'b0;
        @(negedge clk_sys);
        chk("throttle disabled", thr, 1'b0);
        pull = 1'b0;
    endtask : t_ext

    // A short trip halts execution and stays latched after the cause leaves.
    task automatic t_trip;
        trip = 1'b1;
        @(negedge clk_sys) trip = 1'b0;
        chk("thermal_shutdown_n", sd_n, 1'b0);
        chk("exec_halt", halt, 1'b1);
        repeat (5) @(negedge clk_sys);
        chk("thermal_shutdown_n held", sd_n, 1'b0);
        chk("fatal_error_n trip", fe_n, 1'b1);
        do_reset(2);
    endtask : t_trip

    // ------------------------------------------------------------
    // Hang guard and main sequence
    // ------------------------------------------------------------
    // The whole run needs about 140 cycles; 2000 leaves a wide margin.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            test_done();
        end
    end

    initial
    begin
        do_reset(12);
        t_mc();
        t_mc();
        t_internal();
        t_internal_mid();
        t_hot();
        t_ext();
        t_trip();
        test_done();
    end
endmodule : error_thermal_signalling_tb
`default_nettype wire
